// ==== rtl/cio_pkg.sv ====
package cio_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int LINES = 8;
  localparam int PORT_W = 4;
  localparam int LINE0_A = 0;
  localparam int LINE0_B = 4;
  localparam int TOP_LINE = 7;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_PINS = 4'h1;
  localparam logic [3:0] ADDR_IRCTL = 4'h2;
  localparam logic [3:0] ADDR_IRDIV = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int ST_EXT_OSC = 0;
  localparam int ST_CARRIER = 1;
  localparam int ST_EXT_RST = 2;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 200_000_000;
  localparam longint CARRIER_HZ = 38_000;
  localparam logic [15:0] IRDIV_RST = 16'(CLK_HZ / (2 * CARRIER_HZ));
  localparam logic [1:0] IRCTL_RST = 2'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Build option encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IN = 2'b00,
    MODE_OUT = 2'b01,
    MODE_BIDIR = 2'b10
  } cio_mode_t;

  typedef enum logic [1:0] {
    L0_IO = 2'b00,
    L0_RESET = 2'b01,
    L0_IR = 2'b10
  } cio_l0fn_t;

endpackage

// ==== rtl/cio_port_top.sv ====
// Summary of operation
// (R1) Eight lines, two ports, top shares oscillator
// (R2) Each line built input, output or bidirectional
// (R3) Input lines may enable internal pull-up
// (R4) Output lines reset to chosen level
// (R5) Output lines may use large sink current
// (R6) Bidirectional data zero drives pad low
// (R7) Bidirectional data one releases pad
// (R8) Bidirectional pull-up optional, else open-drain
// (R9) Bidirectional low drive offers large sink
// (R10) Line zero may be reset or IR
// (R11) Reset line pull-up is optional
// (R12) IR line: initial level, optional large sink
// (R13) One global pull-up strength for all lines
// (R14) Oscillator use of pad disables top line
// (R15) Pad as I/O forces internal oscillator only
// (R16) Pad levels synchronised before being read
`timescale 1ns/1ps
module cio_port_top #(
  parameter logic [15:0] LINE_MODE = 16'h0000,
  parameter logic [7:0] PULLUP_EN = 8'h00,
  parameter logic [7:0] INIT_HIGH = 8'h00,
  parameter logic [7:0] LARGE_SINK = 8'h00,
  parameter logic [1:0] L0_FUNC_A = 2'b00,
  parameter logic [1:0] L0_FUNC_B = 2'b00,
  parameter logic STRONG_PULL = 1'b0,
  parameter logic PAD_IS_OSC = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic [7:0] padIn,
  output logic [7:0] padOut,
  output logic [7:0] padOe,
  output logic [7:0] padPullUp,
  output logic [7:0] padLargeSink,
  output logic pullStrong,
  output logic extOscEnable,
  output logic intOscOnly,
  output logic extResetReq
);

  // ----------------------------------------------------------------
  // Build option decoding
  // ----------------------------------------------------------------
  function automatic cio_pkg::cio_mode_t lineMode(input int i);
    return cio_pkg::cio_mode_t'(LINE_MODE[2*i +: 2]);
  endfunction

  function automatic cio_pkg::cio_l0fn_t lineFunc(input int i);
    cio_pkg::cio_l0fn_t f;
    f = cio_pkg::L0_IO;
    if (i == cio_pkg::LINE0_A) begin
      f = cio_pkg::cio_l0fn_t'(L0_FUNC_A);
    end else if (i == cio_pkg::LINE0_B) begin
      f = cio_pkg::cio_l0fn_t'(L0_FUNC_B);
    end
    return f;
  endfunction

  function automatic logic lineOff(input int i);
    return PAD_IS_OSC && (i == cio_pkg::TOP_LINE); // (R14)
  endfunction

  function automatic logic [7:0] dataReset();
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < cio_pkg::LINES; i++) begin
      if (lineMode(i) == cio_pkg::MODE_BIDIR) begin
        v[i] = 1'b1;
      end else begin
        v[i] = INIT_HIGH[i]; // (R4)
      end
    end
    return v;
  endfunction

  localparam logic [7:0] DATA_RST = dataReset();

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [1:0] irCtl_q;
  logic [1:0] irCtl_d;
  logic [15:0] irDiv_q;
  logic [15:0] irDiv_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic carrier_q;
  logic carrier_d;
  logic [15:0] rdData_q;
  logic [15:0] rdData_d;
  logic [7:0] padOut_q;
  logic [7:0] padOut_d;
  logic [7:0] padOe_q;
  logic [7:0] padOe_d;
  logic [7:0] pull_q;
  logic [7:0] pull_d;
  logic [7:0] sink_q;
  logic [7:0] sink_d;
  logic pullStrong_q;
  logic extOsc_q;
  logic intOnly_q;
  logic extRst_q;
  logic extRst_d;
  logic [7:0] pins;

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  cio_sync_if syncBus ();

  assign syncBus.raw = padIn;

  cio_sync uSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .bus(syncBus)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    data_d = data_q;
    irCtl_d = irCtl_q;
    irDiv_d = irDiv_q;
    rdData_d = 16'h0000;
    cnt_d = cnt_q + 16'h0001;
    carrier_d = carrier_q;
    extRst_d = 1'b0;
    padOut_d = 8'h00;
    padOe_d = 8'h00;
    pull_d = 8'h00;
    sink_d = 8'h00;

    for (int i = 0; i < cio_pkg::LINES; i++) begin
      pins[i] = lineOff(i) ? 1'b0 : syncBus.sync[i]; // (R16)
    end

    // Carrier generator, half period from divider
    if (cnt_q >= irDiv_q) begin
      cnt_d = 16'h0000;
      carrier_d = ~carrier_q;
    end

    // Register writes
    if (regWr) begin
      if (regAddr == cio_pkg::ADDR_DATA) begin
        data_d = regWrData[7:0];
      end else if (regAddr == cio_pkg::ADDR_IRCTL) begin
        irCtl_d = regWrData[1:0];
      end else if (regAddr == cio_pkg::ADDR_IRDIV) begin
        irDiv_d = regWrData;
      end
    end

    // Register reads, data valid the next cycle
    if (regRd) begin
      if (regAddr == cio_pkg::ADDR_DATA) begin
        rdData_d = {8'h00, data_q};
      end else if (regAddr == cio_pkg::ADDR_PINS) begin
        rdData_d = {8'h00, pins};
      end else if (regAddr == cio_pkg::ADDR_IRCTL) begin
        rdData_d = {14'h0000, irCtl_q};
      end else if (regAddr == cio_pkg::ADDR_IRDIV) begin
        rdData_d = irDiv_q;
      end else if (regAddr == cio_pkg::ADDR_STATUS) begin
        rdData_d[cio_pkg::ST_EXT_OSC] = PAD_IS_OSC;
        rdData_d[cio_pkg::ST_CARRIER] = carrier_q;
        rdData_d[cio_pkg::ST_EXT_RST] = extRst_q;
      end
    end

    // Pad drive per line
    for (int i = 0; i < cio_pkg::LINES; i++) begin // (R1)
      if (lineOff(i)) begin
        padOe_d[i] = 1'b0; // (R14)
      end else if (lineFunc(i) == cio_pkg::L0_RESET) begin
        pull_d[i] = PULLUP_EN[i]; // (R11)
        if (!pins[i]) begin
          extRst_d = 1'b1; // (R10)
        end
      end else if (lineFunc(i) == cio_pkg::L0_IR) begin
        padOe_d[i] = 1'b1; // (R10)
        sink_d[i] = LARGE_SINK[i]; // (R12)
        if (irCtl_q[i / cio_pkg::PORT_W]) begin
          padOut_d[i] = INIT_HIGH[i] ^ carrier_q; // (R12)
        end else begin
          padOut_d[i] = INIT_HIGH[i]; // (R12)
        end
      end else begin
        case (lineMode(i)) // (R2)
          cio_pkg::MODE_OUT: begin
            padOe_d[i] = 1'b1;
            padOut_d[i] = data_q[i];
            sink_d[i] = LARGE_SINK[i]; // (R5)
          end
          cio_pkg::MODE_BIDIR: begin
            padOe_d[i] = ~data_q[i]; // (R6)
            padOut_d[i] = 1'b0; // (R6)
            pull_d[i] = data_q[i] & PULLUP_EN[i]; // (R7) (R8)
            sink_d[i] = LARGE_SINK[i]; // (R9)
          end
          default: begin
            pull_d[i] = PULLUP_EN[i]; // (R3)
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_q <= DATA_RST; // (R4)
      irCtl_q <= cio_pkg::IRCTL_RST;
      irDiv_q <= cio_pkg::IRDIV_RST;
      cnt_q <= cio_pkg::CNT_RST;
      carrier_q <= 1'b0;
      rdData_q <= 16'h0000;
      padOut_q <= 8'h00;
      padOe_q <= 8'h00;
      pull_q <= 8'h00;
      sink_q <= 8'h00;
      pullStrong_q <= 1'b0;
      extOsc_q <= 1'b0;
      intOnly_q <= 1'b1;
      extRst_q <= 1'b0;
    end else if (ce) begin
      data_q <= data_d;
      irCtl_q <= irCtl_d;
      irDiv_q <= irDiv_d;
      cnt_q <= cnt_d;
      carrier_q <= carrier_d;
      rdData_q <= rdData_d;
      padOut_q <= padOut_d;
      padOe_q <= padOe_d;
      pull_q <= pull_d;
      sink_q <= sink_d;
      pullStrong_q <= STRONG_PULL; // (R13)
      extOsc_q <= PAD_IS_OSC; // (R15)
      intOnly_q <= ~PAD_IS_OSC; // (R15)
      extRst_q <= extRst_d;
    end
  end

  assign regRdData = rdData_q;
  assign padOut = padOut_q;
  assign padOe = padOe_q;
  assign padPullUp = pull_q;
  assign padLargeSink = sink_q;
  assign pullStrong = pullStrong_q;
  assign extOscEnable = extOsc_q;
  assign intOscOnly = intOnly_q;
  assign extResetReq = extRst_q;

endmodule

// ==== rtl/cio_sync.sv ====
`timescale 1ns/1ps
module cio_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  cio_sync_if.snk bus
);

  logic [7:0] stage1_q;
  logic [7:0] stage1_d;
  logic [7:0] stage2_q;
  logic [7:0] stage2_d;

  // ----------------------------------------------------------------
  // Two flop synchroniser
  // ----------------------------------------------------------------
  always_comb begin
    stage1_d = bus.raw;
    stage2_d = stage1_q;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_q <= 8'h00;
      stage2_q <= 8'h00;
    end else if (ce) begin
      stage1_q <= stage1_d; // (R16)
      stage2_q <= stage2_d; // (R16)
    end
  end

  assign bus.sync = stage2_q;

endmodule

// ==== rtl/cio_sync_if.sv ====
`timescale 1ns/1ps
interface cio_sync_if;
  logic [7:0] raw;
  logic [7:0] sync;
  modport src (output raw, input sync);
  modport snk (input raw, output sync);
endinterface

// ==== verif/cio_board_model.sv ====
`timescale 1ns/1ps
module cio_board_model #(
  parameter logic [7:0] EXT_PULL = 8'h40
) (
  input wire logic clk_sys,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] padPullUp,
  input wire logic [7:0] keyLow,
  output logic [7:0] padIn
);
  logic wobble_q = 1'h0;
  always_ff @(posedge clk_sys) begin
    wobble_q <= !wobble_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (keyLow[i]) padIn[i] = 1'h0;
      else if (padPullUp[i] || EXT_PULL[i]) padIn[i] = 1'h1;
      else padIn[i] = wobble_q;
    end
  end
endmodule

// ==== verif/cio_port_properties.sv ====
`timescale 1ns/1ps
module cio_port_properties #(
  parameter logic [15:0] LINE_MODE = 16'h0000,
  parameter logic [7:0] PULLUP_EN = 8'h00,
  parameter logic [7:0] LARGE_SINK = 8'h00,
  parameter logic [1:0] L0_FUNC_B = 2'h0,
  parameter logic STRONG_PULL = 1'h0,
  parameter logic PAD_IS_OSC = 1'h0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] regAddr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  input wire logic [7:0] padIn,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] padPullUp,
  input wire logic [7:0] padLargeSink,
  input wire logic pullStrong,
  input wire logic extOscEnable,
  input wire logic intOscOnly,
  input wire logic extResetReq
);
  function automatic logic [7:0] pick(logic [1:0] md);
    for (int i = 0; i < 8; i++) pick[i] = LINE_MODE[2*i+:2] == md;
  endfunction
  localparam logic [7:0] TOP = {PAD_IS_OSC, 7'h00};
  localparam logic [7:0] BID = pick(cio_pkg::MODE_BIDIR) & ~TOP;
  localparam logic [7:0] INM = pick(cio_pkg::MODE_IN) & ~TOP;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence settled;
    $past(!rst && ce);
  endsequence
  sequence padLowRun;
    !padIn[cio_pkg::LINE0_B] [*4];
  endsequence
  sequence pinsRead;
    (ce && $stable(padIn)) [*3] ##0 (regRd && regAddr == cio_pkg::ADDR_PINS);
  endsequence
  sink_select_a: assert property (settled |->
    (padLargeSink & padOe) == (LARGE_SINK & padOe)) else $error("sink bad");
  pull_global_a: assert property (settled |->
    pullStrong == STRONG_PULL) else $error("pull strength bad");
  osc_select_a: assert property (settled |->
    extOscEnable == PAD_IS_OSC && intOscOnly == !PAD_IS_OSC)
    else $error("osc select bad");
  bidir_low_a: assert property (
    (padOut & padOe & BID) == 8'h00) else $error("bidir drives high");
  bidir_pull_a: assert property (settled |->
    ((padPullUp ^ (PULLUP_EN & ~padOe)) & BID) == 8'h00)
    else $error("bidir pull bad");
  input_pull_a: assert property (settled |->
    (padOe & INM) == 8'h00 && ((padPullUp ^ PULLUP_EN) & INM) == 8'h00)
    else $error("input line bad");
  reset_req_a: assert property (padLowRun |->
    extResetReq || L0_FUNC_B != cio_pkg::L0_RESET) else $error("no reset");
  pins_sync_a: assert property (pinsRead |=>
    regRdData == {8'h00, $past(padIn) & ~TOP}) else $error("pins bad");
endmodule

bind cio_port_top cio_port_properties #(
  .LINE_MODE(LINE_MODE), .PULLUP_EN(PULLUP_EN), .LARGE_SINK(LARGE_SINK),
  .L0_FUNC_B(L0_FUNC_B), .STRONG_PULL(STRONG_PULL), .PAD_IS_OSC(PAD_IS_OSC)
) u_props (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .regAddr(regAddr), .regRd(regRd),
  .regRdData(regRdData), .padIn(padIn), .padOut(padOut), .padOe(padOe),
  .padPullUp(padPullUp), .padLargeSink(padLargeSink),
  .pullStrong(pullStrong), .extOscEnable(extOscEnable),
  .intOscOnly(intOscOnly), .extResetReq(extResetReq)
);

// ==== verif/tb_config_io_port_eight_line.sv ====
`timescale 1ns/1ps
module tb_config_io_port_eight_line;
  typedef struct packed {
    logic [7:0] d;
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] pu;
    logic [7:0] pins;
  } cio_row_t;
  logic clk_sys, rst, ce, regWr, regRd, pullStrong, extOscEnable;
  logic intOscOnly, extResetReq, prev;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData, q;
  logic [7:0] padIn, padOut, padOe, padPullUp, padLargeSink, keyLow;
  int errors = 0;
  int testsRun = 0;
  int n;
  cio_row_t rows [4] = '{
    '{8'hFF, 8'h25, 8'h24, 8'h9A, 8'hFF},
    '{8'h00, 8'hED, 8'h00, 8'h12, 8'h13},
    '{8'hA5, 8'h6D, 8'h24, 8'h92, 8'hB7},
    '{8'h5A, 8'hA5, 8'h00, 8'h1A, 8'h5B}
  };
  localparam logic [15:0] MODES = 16'hA491;
  localparam logic [7:0] PULLS = 8'h9A;
  localparam logic [7:0] INITS = 8'h05;
  localparam logic [7:0] SINKS = 8'h0D;
  cio_port_top #(
    .LINE_MODE(MODES), .PULLUP_EN(PULLS), .INIT_HIGH(INITS),
    .LARGE_SINK(SINKS), .L0_FUNC_A(2'h2), .L0_FUNC_B(2'h1),
    .STRONG_PULL(1'h1)
  ) u_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .padPullUp(padPullUp), .padLargeSink(padLargeSink),
    .pullStrong(pullStrong), .extOscEnable(extOscEnable),
    .intOscOnly(intOscOnly), .extResetReq(extResetReq)
  );
  cio_board_model u_board (
    .clk_sys(clk_sys), .padOut(padOut), .padOe(padOe),
    .padPullUp(padPullUp), .keyLow(keyLow), .padIn(padIn)
  );
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    testsRun++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1;
    d = regRdData;
    @(posedge clk_sys);
  endtask
  task automatic report_and_stop;
    if (errors == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
  initial begin
    {rst, ce, regWr, regRd} = 4'hC;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    keyLow = 8'h00;
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rd(cio_pkg::ADDR_DATA, q);
    check("dataInit", 16'h00CD, q);
    rd(cio_pkg::ADDR_IRDIV, q);
    check("irDivInit", cio_pkg::IRDIV_RST, q);
    foreach (rows[i]) begin
      wr(cio_pkg::ADDR_DATA, {8'h00, rows[i].d});
      repeat (3) @(posedge clk_sys);
      #1;
      check("padOe", {8'h00, rows[i].oe}, {8'h00, padOe});
      q = {8'h00, padOut & padOe & 8'hFE};
      check("padOut", {8'h00, rows[i].out}, q);
      check("padPullUp", {8'h00, rows[i].pu}, {8'h00, padPullUp});
      @(posedge clk_sys);
      rd(cio_pkg::ADDR_PINS, q);
      check("pins", {8'h00, rows[i].pins}, q);
      rd(cio_pkg::ADDR_DATA, q);
      check("data", {8'h00, rows[i].d}, q);
    end
    rst <= 1'h1;
    @(posedge clk_sys);
    #1;
    check("oeReset", 16'h0000, {8'h00, padOe});
    q = {13'h0000, pullStrong, extOscEnable, intOscOnly};
    check("oscReset", 16'h0001, q);
    @(posedge clk_sys);
    rst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("oeInit", 16'h0025, {8'h00, padOe});
    check("outInit", 16'h0005, {8'h00, padOut & 8'h25});
    check("pullInit", {8'h00, PULLS}, {8'h00, padPullUp});
    q = {8'h00, padLargeSink & padOe};
    check("sinkInit", 16'h0005, q);
    q = {13'h0000, pullStrong, extOscEnable, intOscOnly};
    check("flags", 16'h0005, q);
    @(posedge clk_sys);
    keyLow <= 8'h02;
    repeat (3) @(posedge clk_sys);
    rd(cio_pkg::ADDR_PINS, q);
    check("pinsKey", 16'h00DD, q);
    keyLow <= 8'h10;
    repeat (4) @(posedge clk_sys);
    #1;
    check("extReset", 16'h0001, {15'h0000, extResetReq});
    @(posedge clk_sys);
    rd(cio_pkg::ADDR_STATUS, q);
    check("status", 16'h0004, q);
    keyLow <= 8'h00;
    repeat (4) @(posedge clk_sys);
    #1;
    check("extResetOff", 16'h0000, {15'h0000, extResetReq});
    @(posedge clk_sys);
    wr(cio_pkg::ADDR_IRDIV, 16'h0004);
    wr(cio_pkg::ADDR_IRCTL, 16'h0001);
    rd(cio_pkg::ADDR_IRCTL, q);
    check("irCtl", 16'h0001, q);
    rd(cio_pkg::ADDR_IRDIV, q);
    check("irDiv", 16'h0004, q);
    repeat (10) @(posedge clk_sys);
    #1;
    prev = padOut[0];
    n = 0;
    repeat (30) begin
      @(posedge clk_sys);
      #1;
      if (padOut[0] !== prev) n++;
      prev = padOut[0];
    end
    check("irToggles", 16'h0006, 16'(n));
    @(posedge clk_sys);
    wr(cio_pkg::ADDR_IRCTL, 16'h0000);
    repeat (8) @(posedge clk_sys);
    #1;
    check("irIdle", 16'h0001, {15'h0000, padOut[0]});
    @(posedge clk_sys);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, q);
    check("unmapped", 16'h0000, q);
    ce <= 1'h0;
    wr(cio_pkg::ADDR_DATA, 16'h0000);
    ce <= 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    check("freezeOe", 16'h0025, {8'h00, padOe});
    @(posedge clk_sys);
    rd(cio_pkg::ADDR_DATA, q);
    check("freezeData", 16'h00CD, q);
    report_and_stop();
  end
endmodule
